// ===== hdl/gpio_alarm_pmu.sv
// Global pins, alarm outputs, performance update and error insert source logic
// Function
// - Eight pins, each independently input, output or alarm output; pins 2, 4, 6 and 8 can also be a global signal.
// - Two pins per port, each can show one selected alarm group.
// - Only one pin of each port pair can be a global signal.
// - Pins of disabled ports still work as input, output or global.
// - Alarm mode pin of a disabled port drives low.
// - Reference, error insert and update pin signals are low when unselected.
// - Pin 2 reference out, 4 reference in, 6 error insert, 8 update in.
// - Pin mode 00 input, 01 alarm, 10 low, 11 high.
// - Alarm codes 0 to 10 select a single alarm in fixed order.
// - Codes 11 to 15 select the documented alarm groups.
// - Event counters saturate at maximum instead of wrapping.
// - Live nonzero bit, latched zero-to-one bit, latched event bit.
// - Update copies counter into holding register and clears counter.
// - Event during update loads counter with one.
// - Update from one-second reference, pin, port bit or global bit.
// - Hardware status follows the update source rise and fall.
// - Latched update status is kept for interrupt use.
// - Ports not using global update are masked from global status.
// - Error insert from local bits, global bit, port bit or pin 6.
// - Source select clear uses local bits, set uses external signal or port bit.
// - Update clear pulses go to all four counter owning ports.
// - One-second reference divides the 8 kHz reference by 8000.
// - One-second rising edge updates when update mode upper bit set.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module gpio_alarm_pmu (
  input wire logic mclk,
  input wire logic resetn,
  input wire gpio_glob_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpio_glob_pkg::NUM_PINS-1:0] pin_in,
  output gpio_glob_pkg::pin_drive_t pin_drive,
  input wire logic [gpio_glob_pkg::NUM_PORTS-1:0] port_enable,
  input wire gpio_glob_pkg::alarm_vec_t [gpio_glob_pkg::NUM_PORTS-1:0] port_alarms,
  input wire logic ref8k_internal,
  input wire logic [gpio_glob_pkg::NUM_PORTS-1:0] count_event,
  input wire logic [gpio_glob_pkg::NUM_PORTS-1:0] local_error_insert,
  output logic [gpio_glob_pkg::NUM_PORTS-1:0] transmit_error_insert,
  output logic [gpio_glob_pkg::NUM_PORTS-1:0] update_clear,
  output logic ref8k_in,
  output logic transmit_error_insert_pin_core,
  output logic pmu_pin_core,
  output logic perf_update_status_latched
);
  import gpio_glob_pkg::*;

  function automatic logic alarm_pick(input alarm_vec_t al, input logic [3:0] code);
    alarm_vec_t mask;
    mask = '0;
    if (code <= AC_LAST_SINGLE) begin
      mask = alarm_vec_t'(1) << code;
    end else begin
      case (code)
        AC_LOS_LOF_AIS: mask = AM_LOS_LOF_AIS;
        AC_PLCP_LCD: mask = AM_PLCP_LCD;
        AC_FIVE: mask = AM_FIVE;
        AC_RAI_GROUP: mask = AM_RAI_GROUP;
        default: mask = AM_ALL;
      endcase
    end
    return |(al & mask);
  endfunction : alarm_pick

  // ==========================================
  // Registers
  logic [5:0] ctrl1_reg;
  logic [1:0] ctrl2_reg;
  logic [2*NUM_PINS-1:0] pin_mode_reg;
  logic [31:0] alarm_sel_reg;
  logic [11:0] port_ctrl_reg;
  logic pms_lat_reg;
  logic ones_lat_reg;
  logic [NUM_PORTS-1:0] nz_lat_reg;
  logic [NUM_PORTS-1:0] ev_lat_reg;
  logic [CNT_W-1:0] cnt_reg [NUM_PORTS];
  logic [CNT_W-1:0] hold_reg [NUM_PORTS];
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic ref8k_prev_reg;
  logic [12:0] div_reg;
  logic onesec_reg;
  logic onesec_prev_reg;
  logic [NUM_PORTS-1:0] req_reg;
  logic pms_prev_reg;

  logic [1:0] gum;
  logic wr_en;
  logic setup;
  logic pms_global;
  logic ref8k_src;
  logic transmit_error_insert_ext;
  logic global_req;
  logic [NUM_PORTS-1:0] port_req;
  logic [NUM_PORTS-1:0] upd;
  logic [NUM_PINS-1:0] claimed;
  logic [NUM_PINS-1:0] w1c_st;
  logic [NUM_PINS-1:0] w1c_cs;

  assign gum = ctrl1_reg[C1_GUM_LO +: 2];
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  assign w1c_st = (wr_en && apb_req.paddr == OFF_STATUS) ? apb_req.pwdata[15:8] : '0;
  assign w1c_cs = (wr_en && apb_req.paddr == OFF_CNT_STATUS) ? apb_req.pwdata[11:4] : '0;

  // ==========================================
  // Pin synchroniser
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================
  // APB slave
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl1_reg <= '0;
      ctrl2_reg <= '0;
      pin_mode_reg <= '0;
      alarm_sel_reg <= '0;
      port_ctrl_reg <= '0;
    end else if (wr_en) begin
      case (apb_req.paddr)
        OFF_CTRL1: ctrl1_reg <= apb_req.pwdata[5:0];
        OFF_CTRL2: ctrl2_reg <= apb_req.pwdata[1:0];
        OFF_PIN_MODE: pin_mode_reg <= apb_req.pwdata[15:0];
        OFF_ALARM_SEL: alarm_sel_reg <= apb_req.pwdata;
        OFF_PORT_CTRL: port_ctrl_reg <= apb_req.pwdata[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= '0;
      if (setup && !apb_req.pwrite) begin
        case (apb_req.paddr)
          OFF_CTRL1: prdata <= 32'(ctrl1_reg);
          OFF_CTRL2: prdata <= 32'(ctrl2_reg);
          OFF_PIN_MODE: prdata <= 32'(pin_mode_reg);
          OFF_ALARM_SEL: prdata <= alarm_sel_reg;
          OFF_PORT_CTRL: prdata <= 32'(port_ctrl_reg);
          OFF_STATUS: prdata <= 32'({ones_lat_reg, pms_lat_reg, pms_prev_reg, sync2_reg});
          OFF_CNT_STATUS: begin
            for (int p = 0; p < NUM_PORTS; p++) begin
              prdata[p] <= cnt_reg[p] != '0;
            end
            prdata[CS_NZ_LAT +: NUM_PORTS] <= nz_lat_reg;
            prdata[CS_EV_LAT +: NUM_PORTS] <= ev_lat_reg;
          end
          default: begin
            if (apb_req.paddr >= OFF_HOLD0 && apb_req.paddr <= OFF_HOLD3
                && apb_req.paddr[1:0] == 2'h0) begin
              prdata <= 32'(hold_reg[apb_req.paddr[3:2]]);
            end else begin
              pslverr <= 1'b1;
            end
          end
        endcase
      end else if (setup) begin
        pslverr <= !(apb_req.paddr inside {OFF_CTRL1, OFF_CTRL2, OFF_PIN_MODE, OFF_ALARM_SEL,
                     OFF_PORT_CTRL, OFF_STATUS, OFF_CNT_STATUS});
      end
    end
  end

  // ==========================================
  // Global signal claim and pin drive
  always_comb begin
    claimed = '0;
    claimed[PIN_R8K_OUT] = ctrl2_reg[C2_R8K_OE];
    claimed[PIN_R8K_IN] = ctrl2_reg[C2_R8K_IS];
    claimed[PIN_TRANSMIT_ERROR_INSERT] = ctrl1_reg[C1_TRANSMIT_ERROR_INSERT_PIN];
    claimed[PIN_PMU] = gum == GUM_PIN;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_drive <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        // Each port owns pins 2p and 2p+1; only the odd one can be global
        if (claimed[i]) begin
          pin_drive.pin_oe[i] <= i == PIN_R8K_OUT;
          pin_drive.pin_out[i] <= (i == PIN_R8K_OUT) && ref8k_src;
        end else begin
          case (pin_mode_reg[2*i +: 2])
            PM_ALARM: begin
              pin_drive.pin_oe[i] <= 1'b1;
              pin_drive.pin_out[i] <= port_enable[i/2] &&
                alarm_pick(port_alarms[i/2], alarm_sel_reg[4*i +: 4]);
            end
            PM_LOW: begin
              pin_drive.pin_oe[i] <= 1'b1;
              pin_drive.pin_out[i] <= 1'b0;
            end
            PM_HIGH: begin
              pin_drive.pin_oe[i] <= 1'b1;
              pin_drive.pin_out[i] <= 1'b1;
            end
            default: begin
              pin_drive.pin_oe[i] <= 1'b0;
              pin_drive.pin_out[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ==========================================
  // Signals from pins into the core
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref8k_in <= 1'b0;
      transmit_error_insert_pin_core <= 1'b0;
      pmu_pin_core <= 1'b0;
    end else begin
      ref8k_in <= claimed[PIN_R8K_IN] && sync2_reg[PIN_R8K_IN];
      transmit_error_insert_pin_core <= claimed[PIN_TRANSMIT_ERROR_INSERT] && sync2_reg[PIN_TRANSMIT_ERROR_INSERT];
      pmu_pin_core <= claimed[PIN_PMU] && sync2_reg[PIN_PMU];
    end
  end

  // ==========================================
  // One-second reference
  assign ref8k_src = ctrl2_reg[C2_R8K_IS] ? sync2_reg[PIN_R8K_IN] : ref8k_internal;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ref8k_prev_reg <= 1'b0;
      div_reg <= '0;
      onesec_reg <= 1'b0;
      onesec_prev_reg <= 1'b0;
      ones_lat_reg <= 1'b0;
    end else begin
      ref8k_prev_reg <= ref8k_src;
      onesec_prev_reg <= onesec_reg;
      if (ref8k_src && !ref8k_prev_reg) begin
        div_reg <= (div_reg == ONESEC_DIV - 13'd1) ? '0 : div_reg + 13'd1;
        onesec_reg <= div_reg < ONESEC_HALF - 13'd1 || div_reg == ONESEC_DIV - 13'd1;
      end
      if (onesec_reg && !onesec_prev_reg) begin
        ones_lat_reg <= 1'b1;
      end else if (w1c_st[ST_ONES_LAT - 8]) begin
        ones_lat_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Update request and status
  always_comb begin
    case (gum)
      GUM_SW: global_req = ctrl1_reg[C1_GPMU];
      GUM_PIN: global_req = sync2_reg[PIN_PMU];
      default: global_req = onesec_reg;
    endcase
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_req[p] = port_ctrl_reg[PC_USEG + p] ? global_req : port_ctrl_reg[PC_PMU + p];
    end
  end

  assign upd = port_req & ~req_reg;
  assign pms_global = |(req_reg & port_ctrl_reg[PC_USEG +: NUM_PORTS]);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_reg <= '0;
      update_clear <= '0;
      pms_prev_reg <= 1'b0;
      pms_lat_reg <= 1'b0;
      perf_update_status_latched <= 1'b0;
    end else begin
      req_reg <= port_req;
      update_clear <= upd;
      pms_prev_reg <= pms_global;
      if (pms_global && !pms_prev_reg) begin
        pms_lat_reg <= 1'b1;
      end else if (w1c_st[ST_PMS_LAT - 8]) begin
        pms_lat_reg <= 1'b0;
      end
      perf_update_status_latched <= pms_lat_reg;
    end
  end

  // ==========================================
  // Event counters
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cnt_reg[p] <= '0;
        hold_reg[p] <= '0;
      end
      nz_lat_reg <= '0;
      ev_lat_reg <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (upd[p]) begin
          hold_reg[p] <= cnt_reg[p];
          cnt_reg[p] <= count_event[p] ? CNT_W'(1) : '0;
        end else if (count_event[p] && cnt_reg[p] != '1) begin
          cnt_reg[p] <= cnt_reg[p] + CNT_W'(1);
        end
        if (count_event[p] && (cnt_reg[p] == '0 || upd[p])) begin
          nz_lat_reg[p] <= 1'b1;
        end else if (w1c_cs[p]) begin
          nz_lat_reg[p] <= 1'b0;
        end
        if (count_event[p]) begin
          ev_lat_reg[p] <= 1'b1;
        end else if (w1c_cs[CS_EV_LAT - CS_NZ_LAT + p]) begin
          ev_lat_reg[p] <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Transmit error insert source
  assign transmit_error_insert_ext = ctrl1_reg[C1_GTMEI] || (claimed[PIN_TRANSMIT_ERROR_INSERT] && sync2_reg[PIN_TRANSMIT_ERROR_INSERT]);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transmit_error_insert <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        transmit_error_insert[p] <= ctrl1_reg[C1_EISS] ?
          (transmit_error_insert_ext || port_ctrl_reg[PC_TRANSMIT_ERROR_INSERT + p]) : local_error_insert[p];
      end
    end
  end

  // ==========================================
  // Assertions
  sequence s_req_rise(int p);
    !req_reg[p] ##1 req_reg[p];
  endsequence

  a_counter_saturates: assert property (@(posedge mclk) disable iff (!resetn)
    (cnt_reg[2] == '1 && !upd[2]) |=> cnt_reg[2] == '1)
    else $error("counter wrapped");
  a_update_loads_one: assert property (@(posedge mclk) disable iff (!resetn)
    (upd[1] && count_event[1]) |=> cnt_reg[1] == CNT_W'(1))
    else $error("event lost at update");
  a_hold_copy: assert property (@(posedge mclk) disable iff (!resetn)
    upd[2] |=> hold_reg[2] == $past(cnt_reg[2]))
    else $error("holding register not loaded");
  a_clear_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    s_req_rise(0) |-> update_clear[0] ##1 !update_clear[0])
    else $error("update clear pulse wrong");
  a_disabled_alarm_low: assert property (@(posedge mclk) disable iff (!resetn)
    (!claimed[2] && pin_mode_reg[5:4] == PM_ALARM && !port_enable[1])
    |=> pin_drive.pin_oe[2] && !pin_drive.pin_out[2])
    else $error("disabled port alarm pin not low");
  a_input_no_drive: assert property (@(posedge mclk) disable iff (!resetn)
    (!claimed[2] && pin_mode_reg[5:4] == PM_INPUT) |=> !pin_drive.pin_oe[2])
    else $error("input pin driven");
  a_unselected_low: assert property (@(posedge mclk) disable iff (!resetn)
    !claimed[PIN_R8K_IN] |=> !ref8k_in)
    else $error("reference input not forced low");
  a_pms_mask: assert property (@(posedge mclk) disable iff (!resetn)
    (port_ctrl_reg[PC_USEG +: NUM_PORTS] == '0) |-> !pms_global)
    else $error("masked port reached global status");
  a_pms_latch: assert property (@(posedge mclk) disable iff (!resetn)
    (pms_global && !pms_prev_reg) |=> pms_lat_reg ##1 perf_update_status_latched)
    else $error("update status not latched");
  a_err_src: assert property (@(posedge mclk) disable iff (!resetn)
    !ctrl1_reg[C1_EISS] |=> transmit_error_insert[0] == $past(local_error_insert[0]))
    else $error("local error insert not used");
endmodule : gpio_alarm_pmu

// ===== hdl/gpio_glob_pkg.sv
// Package with the register map, field layout and types of the global pin block
package gpio_glob_pkg;
  // ==========================================
  // Sizes
  localparam int NUM_PINS = 8;
  localparam int NUM_PORTS = 4;
  localparam int NUM_ALARMS = 11;
  localparam int CNT_W = 16;
  localparam logic [12:0] ONESEC_DIV = 13'd8000;
  localparam logic [12:0] ONESEC_HALF = 13'd4000;
  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_PIN_MODE = 8'h08;
  localparam logic [7:0] OFF_ALARM_SEL = 8'h0c;
  localparam logic [7:0] OFF_PORT_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_CNT_STATUS = 8'h18;
  localparam logic [7:0] OFF_HOLD0 = 8'h20;
  localparam logic [7:0] OFF_HOLD3 = 8'h2c;
  // ==========================================
  // Field positions
  localparam int C1_GUM_LO = 0;
  localparam int C1_EISS = 2;
  localparam int C1_GTMEI = 3;
  localparam int C1_GPMU = 4;
  localparam int C1_TRANSMIT_ERROR_INSERT_PIN = 5;
  localparam int C2_R8K_OE = 0;
  localparam int C2_R8K_IS = 1;
  localparam int PC_TRANSMIT_ERROR_INSERT = 0;
  localparam int PC_PMU = 4;
  localparam int PC_USEG = 8;
  localparam int ST_PMS = 8;
  localparam int ST_PMS_LAT = 9;
  localparam int ST_ONES_LAT = 10;
  localparam int CS_NZ_LAT = 4;
  localparam int CS_EV_LAT = 8;
  // Pin indices of global signals (pins numbered from 0)
  localparam int PIN_R8K_OUT = 1;
  localparam int PIN_R8K_IN = 3;
  localparam int PIN_TRANSMIT_ERROR_INSERT = 5;
  localparam int PIN_PMU = 7;
  // ==========================================
  // Encodings
  localparam logic [1:0] PM_INPUT = 2'h0;
  localparam logic [1:0] PM_ALARM = 2'h1;
  localparam logic [1:0] PM_LOW = 2'h2;
  localparam logic [1:0] PM_HIGH = 2'h3;
  localparam logic [1:0] GUM_SW = 2'h0;
  localparam logic [1:0] GUM_PIN = 2'h1;
  localparam logic [10:0] AM_LOS_LOF_AIS = 11'h00d;
  localparam logic [10:0] AM_PLCP_LCD = 11'h480;
  localparam logic [10:0] AM_FIVE = 11'h48d;
  localparam logic [10:0] AM_RAI_GROUP = 11'h130;
  localparam logic [10:0] AM_ALL = 11'h7ff;
  localparam logic [3:0] AC_LAST_SINGLE = 4'ha;
  localparam logic [3:0] AC_LOS_LOF_AIS = 4'hb;
  localparam logic [3:0] AC_PLCP_LCD = 4'hc;
  localparam logic [3:0] AC_FIVE = 4'hd;
  localparam logic [3:0] AC_RAI_GROUP = 4'he;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef logic [NUM_ALARMS-1:0] alarm_vec_t;
  typedef struct packed {
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
  } pin_drive_t;
endpackage : gpio_glob_pkg

// ===== verification/board_pins.sv
// Board-side model of the eight general-purpose pins
`timescale 1ns/1ps
module board_pins
  import gpio_glob_pkg::*;
(
  input wire gpio_glob_pkg::pin_drive_t pin_drive,
  input wire logic [gpio_glob_pkg::NUM_PINS-1:0] board_level,
  output logic [gpio_glob_pkg::NUM_PINS-1:0] pin_in
);
  // ==========================================
  // Wire level: a driven pin reads back the device, else the board drives it
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = pin_drive.pin_oe[i] ? pin_drive.pin_out[i] : board_level[i];
    end
  end
endmodule : board_pins

// ===== verification/gpio_alarm_pmu_bench.sv
// Self-checking bench of the global pin, alarm, update and error insert block
`timescale 1ns/1ps
module gpio_alarm_pmu_bench;
  import gpio_glob_pkg::*;
  logic mclk;
  logic resetn;
  apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_PINS-1:0] pin_in;
  logic [NUM_PINS-1:0] lvl;
  pin_drive_t drive;
  logic [NUM_PORTS-1:0] port_enable;
  alarm_vec_t [NUM_PORTS-1:0] alarms;
  logic ref8k;
  logic [NUM_PORTS-1:0] ev;
  logic [NUM_PORTS-1:0] lei;
  logic [NUM_PORTS-1:0] tei;
  logic [NUM_PORTS-1:0] uclr;
  logic [NUM_PORTS-1:0] uclr_seen;
  logic r8in;
  logic tpin;
  logic ppin;
  logic psl;
  logic [31:0] rdv;
  logic erv;
  int failures = 0;
  int checked = 0;
  int since = 0;
  int gap = 0;
  int n0;
  gpio_alarm_pmu DUT (.mclk(mclk), .resetn(resetn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_drive(drive),
    .port_enable(port_enable), .port_alarms(alarms), .ref8k_internal(ref8k),
    .count_event(ev), .local_error_insert(lei), .transmit_error_insert(tei),
    .update_clear(uclr), .ref8k_in(r8in), .transmit_error_insert_pin_core(tpin), .pmu_pin_core(ppin),
    .perf_update_status_latched(psl));
  board_pins board (.pin_drive(drive), .board_level(lvl), .pin_in(pin_in));
  // ==========================================
  // Reporting
  task automatic finish_test;
    $display("Counts: %0d compared, %0d failed", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hang;
    failures++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    finish_test();
  endtask : hang
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  // ==========================================
  // APB master: setup, then access until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    erv = pslverr;
    req <= '0;
    if (n >= 20) hang();
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Software update: raise request, wait for status, drop request
  task automatic update;
    int n;
    wr(OFF_CTRL1, 32'h00000010);
    n = 0;
    do begin
      rd(OFF_STATUS);
      n++;
    end while (rdv[ST_PMS] !== 1'b1 && n < 20);
    if (n >= 20) hang();
    wr(OFF_CTRL1, 32'h0);
    idle(4);
  endtask : update
  function automatic alarm_vec_t amask(input logic [3:0] c);
    case (c)
      4'hb: return 11'h00d;
      4'hc: return 11'h480;
      4'hd: return 11'h48d;
      4'he: return 11'h130;
      4'hf: return 11'h7ff;
      default: return 11'h001 << c;
    endcase
  endfunction : amask
  // Gap between update pulses of port 1, and every port that pulsed
  always @(posedge mclk) begin
    if (uclr[1] === 1'b1) begin
      gap <= since;
      since <= 1;
    end else begin
      since <= since + 1;
    end
    if (uclr !== 4'h0) begin
      uclr_seen <= uclr_seen | uclr;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    req = '0;
    lvl = '0;
    port_enable = '1;
    alarms = '0;
    ref8k = 1'b0;
    ev = '0;
    lei = '0;
    uclr_seen = '0;
    void'($urandom(14001));
    idle(6);
    resetn <= 1'b1;
    idle(2);
    check(drive.pin_oe, 8'h00);
    rd(OFF_PIN_MODE);
    check(rdv, 32'h0);
    rd(8'h1c);
    check(erv, 1'b1);
    check(rdv, 32'h0);
    $display("test reset done");
    wr(OFF_PIN_MODE, 32'h0000aaaa);
    idle(3);
    check(drive, 16'h00ff);
    wr(OFF_PIN_MODE, 32'h0000ffff);
    idle(3);
    check(drive, 16'hffff);
    wr(OFF_PIN_MODE, 32'h0);
    lvl <= 8'($urandom);
    idle(6);
    rd(OFF_STATUS);
    check(rdv[7:0], lvl);
    $display("test pin modes done");
    wr(OFF_PIN_MODE, 32'h00005555);
    for (int c = 0; c < 16; c++) begin
      for (int p = 0; p < NUM_PORTS; p++) alarms[p] <= alarm_vec_t'($urandom);
      wr(OFF_ALARM_SEL, {8{4'(c)}});
      idle(3);
      for (int i = 0; i < NUM_PINS; i++) begin
        check(drive.pin_out[i], |(alarms[i/2] & amask(4'(c))));
      end
    end
    port_enable <= 4'h5;
    alarms <= '1;
    idle(3);
    check(drive, {8'h33, 8'hff});
    wr(OFF_PIN_MODE, 32'h000055f5);
    idle(3);
    check(drive, {8'h3f, 8'hff});
    $display("test alarm pins done");
    port_enable <= '1;
    wr(OFF_PIN_MODE, 32'h0);
    wr(OFF_PORT_CTRL, 32'h00000f00);
    wr(OFF_CTRL2, 32'h3);
    wr(OFF_CTRL1, 32'h00000021);
    lvl <= 8'ha8;
    ref8k <= 1'b1;
    idle(6);
    check(drive, {8'h02, 8'h02});
    check({r8in, tpin, ppin}, 3'b111);
    rd(OFF_STATUS);
    check(rdv[ST_PMS], 1'b1);
    lvl <= 8'h00;
    ref8k <= 1'b0;
    idle(6);
    check({drive.pin_out[1], r8in, tpin, ppin}, 4'h0);
    rd(OFF_STATUS);
    check(rdv[ST_PMS], 1'b0);
    wr(OFF_CTRL2, 32'h0);
    wr(OFF_CTRL1, 32'h0);
    lvl <= 8'hff;
    idle(6);
    check({r8in, tpin, ppin}, 3'b000);
    $display("test global pins done");
    lei <= 4'($urandom);
    idle(3);
    check(tei, lei);
    wr(OFF_CTRL1, 32'h0000000c);
    idle(3);
    check(tei, 4'hf);
    wr(OFF_CTRL1, 32'h00000004);
    wr(OFF_PORT_CTRL, 32'h00000f05);
    idle(3);
    check(tei, 4'h5);
    wr(OFF_PORT_CTRL, 32'h00000f00);
    wr(OFF_CTRL1, 32'h00000024);
    idle(6);
    check(tei, 4'hf);
    wr(OFF_CTRL1, 32'h0);
    $display("test error insert done");
    n0 = 1 + $urandom % 20;
    for (int k = 0; k < n0; k++) begin
      @(posedge mclk);
      ev[0] <= 1'b1;
      @(posedge mclk);
      ev[0] <= 1'b0;
    end
    idle(2);
    rd(OFF_CNT_STATUS);
    check({rdv[CS_EV_LAT], rdv[CS_NZ_LAT], rdv[0]}, 3'b111);
    wr(OFF_STATUS, 32'h00000200);
    ev[2:1] <= 2'b11;
    uclr_seen <= '0;
    update();
    check(uclr_seen, 4'hf);
    check(psl, 1'b1);
    rd(OFF_HOLD0);
    check(rdv, 32'(n0));
    update();
    rd(OFF_HOLD0 + 8'h04);
    check(rdv, 32'(gap));
    rd(OFF_HOLD0);
    check(rdv, 32'h0);
    rd(OFF_CNT_STATUS);
    check({rdv[CS_EV_LAT], rdv[CS_NZ_LAT], rdv[0]}, 3'b110);
    wr(OFF_CNT_STATUS, 32'h00000111);
    wr(OFF_STATUS, 32'h00000600);
    idle(3);
    rd(OFF_CNT_STATUS);
    check({rdv[CS_EV_LAT], rdv[CS_NZ_LAT]}, 2'b00);
    check(psl, 1'b0);
    // Port 0 follows the one-second reference while port 2 runs into saturation
    wr(OFF_PORT_CTRL, 32'h00000100);
    wr(OFF_CTRL1, 32'h00000002);
    uclr_seen <= '0;
    for (int k = 0; k < 33000; k++) begin
      @(posedge mclk);
      ref8k <= 1'b1;
      @(posedge mclk);
      ref8k <= 1'b0;
    end
    rd(OFF_STATUS);
    check(rdv[ST_ONES_LAT], 1'b1);
    check(uclr_seen, 4'h1);
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_PORT_CTRL, 32'h00000f00);
    update();
    rd(OFF_HOLD0 + 8'h08);
    check(rdv, 32'h0000ffff);
    ev <= '0;
    wr(OFF_PORT_CTRL, 32'h000000f0);
    wr(OFF_CTRL1, 32'h00000010);
    idle(4);
    rd(OFF_STATUS);
    check(rdv[ST_PMS], 1'b0);
    wr(OFF_CTRL1, 32'h0);
    $display("test counters done");
    wr(OFF_PIN_MODE, 32'h0000ffff);
    @(posedge mclk);
    resetn <= 1'b0;
    idle(3);
    check(drive, 16'h0000);
    resetn <= 1'b1;
    rd(OFF_PIN_MODE);
    check(rdv, 32'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule : gpio_alarm_pmu_bench
